// file: rtl/bit_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser; the first stage feeds only the second
module bit_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;

  // Plain shift, no reset, so the stages never see a port under reset
  always_ff @(posedge clk) begin
    meta <= din;
    dout <= meta;
  end
endmodule : bit_sync

// file: rtl/link_phy_pkg.sv
`include "link_phy_regs.svh"

package link_phy_pkg;

  typedef enum logic [1:0] {ST_DEACT, ST_SUSP, ST_RESUME, ST_ACT} linkState_e;

  typedef logic [`LNK_CNT_W-1:0] cnt_t;

  // Everything clocked by the link clock
  typedef struct packed {
    linkState_e state;
    cnt_t hiCnt;
    cnt_t loCnt;
    cnt_t perCnt;
    cnt_t hiLen;
    logic vPrev;
    logic current;
    logic [`LNK_BITCNT_W-1:0] bitCnt;
    logic rxBit;
    logic rxTgl;
    logic ackTgl;
    logic sofOwed;
  } link_s;

  // Everything clocked by the system clock
  typedef struct packed {
    logic rxBit;
    logic rxValid;
    logic rxTglPrev;
    logic reqTgl;
    logic txData;
    logic txReady;
    logic [2:0] stPrev;
    logic [1:0] linkState;
    logic sofDue;
  } core_s;

endpackage : link_phy_pkg

// file: rtl/link_phy_regs.svh
// Function
// RQ1: Master codes one as three quarters high, zero as one quarter high.
// RQ2: Bits run back to back, rising edge to rising edge, period may vary.
// RQ3: Master keeps high time of a one within 0.70 to 0.80 of the period.
// RQ4: Master keeps high time of a zero within 0.20 to 0.30 of the period.
// RQ5: Bit period is 1 to 5 us, or 0.590 to 10 us when extended.
// RQ6: Master samples slave current only while the voltage is high.
// RQ7: Slave changes current only while voltage is low, except slave resume.
// RQ8: Link starts suspended at activation: voltage high, current low.
// RQ9: Deactivated means voltage and current both low until activation.
// RQ10: Activated link exchanges bits until the master suspends it.
// RQ11: Master resume is a transition sequence plus exactly 8 idle bits.
// RQ12: Slave may start sending frames during the master resume idle bits.
// RQ13: After acknowledged no-more-activity, master resumes via deactivate and activate.
// RQ14: Slave requests resume from suspended by driving its current high.
// RQ15: Master answers extended slave resume within 20 ms under stated conditions.
// RQ16: Otherwise master answers slave resume within 5 us.
// RQ17: After slave resume, slave starts its start flag within 4 bits.
// RQ18: Master suspends by holding voltage high after at least 7 idle bits.
// RQ19: Master deactivates by holding the contact low over 100 us.
// RQ20: Idle bits between frames carry logical zero.
// RQ21: Slave decodes a bit by comparing high time with half the period.
`ifndef LINK_PHY_REGS_SVH
`define LINK_PHY_REGS_SVH

`define LNK_CLK_PERIOD_NS 125
`define LNK_BIT_MAX_NS 10000
`define LNK_DEACT_LOW_NS 100000
`define LNK_SUSP_HIGH_CYC ((`LNK_BIT_MAX_NS + `LNK_CLK_PERIOD_NS - 1) / `LNK_CLK_PERIOD_NS)
`define LNK_DEACT_CYC ((`LNK_DEACT_LOW_NS + `LNK_CLK_PERIOD_NS - 1) / `LNK_CLK_PERIOD_NS)
`define LNK_CNT_W 10
`define LNK_RESUME_IDLE_BITS 8
`define LNK_SOF_MAX_BITS 4
`define LNK_BITCNT_W 4

`endif

// file: rtl/link_phy_slave.sv
`timescale 1ns/10ps
`include "link_phy_regs.svh"
// Card-side physical layer of the single-wire link
module link_phy_slave (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic linkClk,
  input wire logic masterVoltage,
  output logic slaveCurrent,
  input wire logic txValid,
  input wire logic txBit,
  output logic txReady,
  input wire logic wakeReq,
  output logic rxBit,
  output logic rxValid,
  output logic [1:0] linkState,
  output logic sofDue
);
  localparam link_phy_pkg::cnt_t SUSP_CYC = link_phy_pkg::cnt_t'(`LNK_SUSP_HIGH_CYC); // see RQ5
  localparam link_phy_pkg::cnt_t DEACT_CYC = link_phy_pkg::cnt_t'(`LNK_DEACT_CYC);
  localparam logic [`LNK_BITCNT_W-1:0] IDLE_LAST = `LNK_BITCNT_W'(`LNK_RESUME_IDLE_BITS - 1);
  localparam logic [`LNK_BITCNT_W-1:0] SOF_LAST = `LNK_BITCNT_W'(`LNK_SOF_MAX_BITS - 1);

  // Saturating counter step, so long holds never wrap into short ones
  function automatic link_phy_pkg::cnt_t satInc(input link_phy_pkg::cnt_t v);
    satInc = (v == '1) ? v : link_phy_pkg::cnt_t'(v + 1'b1);
  endfunction : satInc

  link_phy_pkg::link_s lq, ld;
  link_phy_pkg::core_s cq, cd;

  // Link-side view of pins and system-side signals
  logic [3:0] lnkSync;
  logic vHigh;
  logic lnkRstN;
  logic reqS;
  logic wakeS;
  assign vHigh = lnkSync[3];
  assign lnkRstN = lnkSync[2];
  assign reqS = lnkSync[1];
  assign wakeS = lnkSync[0];

  bit_sync #(.W(4)) u_lnk_sync (
    .clk(linkClk),
    .din({masterVoltage, reset_n, cq.reqTgl, wakeReq}),
    .dout(lnkSync)
  );

  // System-side view of link events and state
  logic [4:0] coreSync;
  logic rxTglS;
  logic ackS;
  logic [2:0] stS;
  assign rxTglS = coreSync[4];
  assign ackS = coreSync[3];
  assign stS = coreSync[2:0];

  bit_sync #(.W(5)) u_core_sync (
    .clk(clk),
    .din({lq.rxTgl, lq.ackTgl, lq.state, lq.sofOwed}),
    .dout(coreSync)
  );

  // Link-domain next state: edge timing, decode, state walk, load switch
  logic rise;
  logic fall;
  logic decoded;
  logic takeTx;
  always_comb begin
    ld = lq;
    rise = vHigh & ~lq.vPrev;
    fall = ~vHigh & lq.vPrev;
    decoded = 1'b0;
    takeTx = 1'b0;
    ld.vPrev = vHigh;

    // High and low times restart at each level change; period restarts at each rise
    if (vHigh) begin
      ld.hiCnt = satInc(lq.hiCnt);
      ld.loCnt = '0;
    end else begin
      ld.loCnt = satInc(lq.loCnt);
      ld.hiCnt = '0;
    end
    ld.perCnt = rise ? link_phy_pkg::cnt_t'(1) : satInc(lq.perCnt); // see RQ2
    if (fall) begin
      ld.hiLen = lq.hiCnt;
    end

    // Long high time against half the measured period; no fixed period assumed
    decoded = {lq.hiLen, 1'b0} > {1'b0, lq.perCnt}; // see RQ21 see RQ2

    unique case (lq.state)
      link_phy_pkg::ST_DEACT: begin
        ld.current = 1'b0; // see RQ9
        if (vHigh) begin
          ld.state = link_phy_pkg::ST_SUSP; // see RQ8
        end
      end
      link_phy_pkg::ST_SUSP: begin
        // Only case where the load may switch while the voltage is high
        ld.current = wakeS & vHigh; // see RQ14 see RQ7 see RQ8
        if (fall) begin
          ld.bitCnt = '0;
          if (lq.current) begin
            ld.state = link_phy_pkg::ST_ACT; // see RQ17
            ld.sofOwed = 1'b1;
          end else begin
            ld.state = link_phy_pkg::ST_RESUME; // see RQ11
          end
          takeTx = 1'b1;
        end
      end
      link_phy_pkg::ST_RESUME, link_phy_pkg::ST_ACT: begin
        if (rise) begin
          ld.rxBit = decoded;
          ld.rxTgl = ~lq.rxTgl;
          if (lq.state == link_phy_pkg::ST_RESUME) begin
            ld.bitCnt = lq.bitCnt + 1'b1;
            if (lq.bitCnt == IDLE_LAST) begin
              ld.state = link_phy_pkg::ST_ACT; // see RQ11 see RQ10
            end
          end else if (lq.sofOwed) begin
            ld.bitCnt = lq.bitCnt + 1'b1;
            if (lq.bitCnt == SOF_LAST) begin
              ld.sofOwed = 1'b0; // Window for the start flag has closed
            end
          end
        end
        takeTx = fall; // see RQ12
        // Voltage held high past the longest bit means the master suspended
        if (lq.hiCnt >= SUSP_CYC) begin
          ld.state = link_phy_pkg::ST_SUSP; // see RQ10
        end
      end
    endcase

    // Load changes only on the falling edge; idle is a zero bit
    if (takeTx) begin
      if (reqS != lq.ackTgl) begin
        ld.current = cq.txData; // see RQ7
        ld.ackTgl = ~lq.ackTgl;
        ld.sofOwed = 1'b0;
      end else begin
        ld.current = 1'b0; // see RQ20 see RQ7
      end
    end

    // Contact low past the deactivation time wins over everything
    if (lq.loCnt >= DEACT_CYC) begin
      ld.state = link_phy_pkg::ST_DEACT; // see RQ9
      ld.current = 1'b0;
      ld.sofOwed = 1'b0;
    end
  end

  // Link-domain register; reset taken from the synchronised system reset
  always_ff @(posedge linkClk) begin
    if (!lnkRstN) begin
      lq <= '0;
    end else begin
      lq <= ld;
    end
  end

  // System-domain next state: bit delivery, transmit handshake, status
  always_comb begin
    cd = cq;
    cd.rxValid = 1'b0;
    if (rxTglS != cq.rxTglPrev) begin
      cd.rxBit = lq.rxBit; // Held stable by the link until its next rise
      cd.rxValid = 1'b1;
      cd.rxTglPrev = rxTglS;
    end
    // One bit in flight at a time; data held until the link acknowledges
    if (txValid && cq.txReady) begin
      cd.txData = txBit;
      cd.reqTgl = ~cq.reqTgl;
      cd.txReady = 1'b0;
    end else begin
      cd.txReady = (cq.reqTgl == ackS);
    end
    // Status bits change slowly; take them only when two samples agree
    cd.stPrev = stS;
    if (stS == cq.stPrev) begin
      cd.linkState = stS[2:1];
      cd.sofDue = stS[0]; // see RQ17
    end
  end

  // System-domain register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cq <= '0;
    end else begin
      cq <= cd;
    end
  end

  // Outputs straight from flip-flops
  assign slaveCurrent = lq.current;
  assign txReady = cq.txReady;
  assign rxBit = cq.rxBit;
  assign rxValid = cq.rxValid;
  assign linkState = cq.linkState;
  assign sofDue = cq.sofDue;

endmodule : link_phy_slave

// file: verif/link_phy_slave_bench.sv
`timescale 1ns/10ps
module link_phy_slave_bench;
  logic clk, linkClk, reset_n, txValid, txBit, wakeReq, masterVoltage;
  logic slaveCurrent, txReady, rxBit, rxValid, sofDue;
  logic [1:0] linkState;
  logic [31:0] rxHist;
  int rxCount = 0;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  link_phy_slave link_phy_slave_i (.clk(clk), .reset_n(reset_n), .linkClk(linkClk),
    .masterVoltage(masterVoltage), .slaveCurrent(slaveCurrent), .txValid(txValid), .txBit(txBit),
    .txReady(txReady), .wakeReq(wakeReq), .rxBit(rxBit), .rxValid(rxValid), .linkState(linkState),
    .sofDue(sofDue));
  master_model master_model_i (.masterVoltage(masterVoltage), .slaveCurrent(slaveCurrent));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Offset start keeps the link clock unrelated in phase
  initial begin
    linkClk = 1'b0;
    #7.3;
    forever #62.5 linkClk = ~linkClk;
  end
  // Received bit history and hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (rxValid === 1'b1) begin
      rxHist <= {rxHist[30:0], rxBit};
      rxCount <= rxCount + 1;
    end
    if (cycles == 60000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : checkVal
  task automatic waitState(input logic [1:0] s);
    for (int i = 0; i < 2000 && linkState !== s; i++) @(posedge clk);
    checkVal({30'h0, linkState}, {30'h0, s});
  endtask : waitState
  task automatic offerTx(input logic b);
    @(posedge clk);
    txValid <= 1'b1;
    txBit <= b;
    @(posedge clk);
    txValid <= 1'b0;
  endtask : offerTx
  task automatic testMasterResume;
    int base;
    base = rxCount;
    master_model_i.resume();
    waitState(2'h3);
    for (int i = 3; i >= 0; i--) master_model_i.sendBit(i != 2);
    fork offerTx(1'b1); join_none
    master_model_i.sendBit(1'b0);
    master_model_i.sendBit(1'b0);
    checkVal({31'h0, master_model_i.seenCurrent}, 32'h1);
    master_model_i.sendBit(1'b0);
    checkVal({31'h0, master_model_i.seenCurrent}, 32'h0);
    repeat (7) master_model_i.sendBit(1'b0);
    master_model_i.hold(1'b1, 12000);
    waitState(2'h1);
    checkVal(32'(rxCount - base), 32'h17);
    checkVal(rxHist & 32'h3fff, 32'h2c00);
    $display("done masterResume");
  endtask : testMasterResume
  task automatic testSlaveResume;
    @(posedge clk);
    wakeReq <= 1'b1;
    repeat (40) @(posedge clk);
    checkVal({31'h0, slaveCurrent}, 32'h1);
    master_model_i.hold(1'b0, 1000);
    waitState(2'h3);
    checkVal({31'h0, sofDue}, 32'h1);
    @(posedge clk);
    wakeReq <= 1'b0;
    fork offerTx(1'b0); join_none
    repeat (2) master_model_i.sendBit(1'b0);
    checkVal({31'h0, master_model_i.seenCurrent}, 32'h0);
    repeat (3) master_model_i.sendBit(1'b0);
    repeat (10) @(posedge clk);
    checkVal({31'h0, sofDue}, 32'h0);
    checkVal({31'h0, txReady}, 32'h1);
    repeat (3) master_model_i.sendBit(1'b0);
    master_model_i.hold(1'b1, 12000);
    waitState(2'h1);
    $display("done slaveResume");
  endtask : testSlaveResume
  task automatic testDeactivate;
    master_model_i.hold(1'b0, 110000);
    waitState(2'h0);
    checkVal({31'h0, slaveCurrent}, 32'h0);
    master_model_i.hold(1'b1, 3000);
    waitState(2'h1);
    $display("done deactivate");
  endtask : testDeactivate
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  // Reset outlasts the link side's own reset synchroniser
  initial begin
    reset_n = 1'b0;
    txValid = 1'b0;
    txBit = 1'b0;
    wakeReq = 1'b0;
    repeat (30) @(posedge clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    checkVal({30'h0, linkState}, 32'h0);
    master_model_i.hold(1'b1, 3000);
    waitState(2'h1);
    testMasterResume();
    testSlaveResume();
    testDeactivate();
    tally_and_finish();
  end
endmodule : link_phy_slave_bench

// file: verif/link_phy_slave_checker.sv
`timescale 1ns/10ps
module link_phy_slave_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic linkClk,
  input wire logic masterVoltage,
  input wire logic slaveCurrent,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic wakeReq,
  input wire logic rxValid,
  input wire logic [1:0] linkState,
  input wire logic sofDue
);
  logic [2:0] sofBits;
  // Bits received while the start flag is still owed
  always_ff @(posedge clk) sofBits <= sofDue ? sofBits + 3'(rxValid) : 3'h0;
  chk_rx_single: assert property (@(posedge clk) disable iff (!reset_n)
    rxValid |=> !rxValid [*8]) else $error("rx pulse too close");
  chk_rx_live: assert property (@(posedge clk) disable iff (!reset_n)
    rxValid |-> linkState[1]) else $error("bit decoded while idle");
  chk_tx_take: assert property (@(posedge clk) disable iff (!reset_n)
    txValid && txReady |=> !txReady) else $error("ready held after take");
  chk_sof_state: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(sofDue) |-> ##[0:4] linkState == 2'h3) else $error("flag owed off line");
  chk_sof_bound: assert property (@(posedge clk) disable iff (!reset_n)
    sofDue |-> sofBits < 3'h5) else $error("flag owed too long");
  chk_switch_low: assert property (@(posedge linkClk) disable iff (!reset_n)
    $changed(slaveCurrent) && linkState[1] |-> !masterVoltage) else $error("load switched high");
  chk_deact_quiet: assert property (@(posedge linkClk) disable iff (!reset_n)
    (linkState == 2'h0 && !masterVoltage) [*4] |-> !slaveCurrent) else $error("load on when off");
  chk_susp_quiet: assert property (@(posedge linkClk) disable iff (!reset_n)
    (linkState == 2'h1 && !wakeReq && masterVoltage) [*6] |-> !slaveCurrent) else $error("load on");
  chk_wake_drive: assert property (@(posedge linkClk) disable iff (!reset_n)
    (linkState == 2'h1 && wakeReq && masterVoltage) [*6] |-> slaveCurrent) else $error("no wake");
endmodule : link_phy_slave_checker
bind link_phy_slave link_phy_slave_checker link_phy_slave_checker_i (.clk(clk), .reset_n(reset_n),
  .linkClk(linkClk), .masterVoltage(masterVoltage), .slaveCurrent(slaveCurrent), .txValid(txValid),
  .txReady(txReady), .wakeReq(wakeReq), .rxValid(rxValid), .linkState(linkState), .sofDue(sofDue));

// file: verif/master_model.sv
`timescale 1ns/10ps
module master_model #(
  parameter int BIT_NS = 4000
) (
  output logic masterVoltage,
  input wire logic slaveCurrent
);
  logic seenCurrent = 1'b0;
  initial masterVoltage = 1'b0;
  // One bit from rising edge to rising edge; the high time codes it
  task automatic sendBit(input logic b);
    int hi;
    hi = b ? BIT_NS * 3 / 4 : BIT_NS / 4;
    masterVoltage = 1'b1;
    #(hi);
    seenCurrent = slaveCurrent;
    masterVoltage = 1'b0;
    #(BIT_NS - hi);
  endtask : sendBit
  // Transition bit then the fixed run of idle zeros
  task automatic resume;
    masterVoltage = 1'b0;
    #(BIT_NS * 3 / 4);
    repeat (8) sendBit(1'b0);
  endtask : resume
  // Held level: high suspends, long low deactivates
  task automatic hold(input logic lvl, input int ns);
    masterVoltage = lvl;
    #(ns);
  endtask : hold
endmodule : master_model
